// ---- design/spi_fifo_port.sv ----
// serial port with four-entry fifos, master or slave, ahb-lite registers
module spi_fifo_port (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// serial pins
	input wire logic shift_clock_pin_i,
	output logic shift_clock_pin_o,
	output logic shift_clock_pin_oe_o,
	input wire logic select_line_i,
	output logic select_line_o,
	output logic select_line_oe_o,
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	input wire logic serial_in_pin_i,
	// event request
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////
	// state
	typedef struct packed {
		logic en, mst, cpol, cpha, lsb, size16, flush, mdfe, moz, soz, ssz;
		logic [9:0] div; // clock_divisor
		logic [1:0] lead, lag; // half clocks minus one
		logic [7:0] gap; // gap_length in shift clocks
		logic [2:0] tth, rth; // threshold selections
		logic [3:0] ien; // event enables
		logic f_tth, f_rth, f_end, f_ovr, f_mdf, f_done, f_wof; // sticky flags
		logic [3:0][15:0] txm, rxm; // fifo storage
		logic [1:0] tx_rp, rx_rp; // read indices
		logic [2:0] tx_cnt, rx_cnt; // depths
		spi_fifo_port_pkg::mst_t state;
		logic [9:0] hcnt; // divider count
		logic [8:0] tcnt; // half clocks in lead, lag, gap, guard
		logic [4:0] ecnt; // clock edge within a unit
		logic [1:0] lead_l, lag_l; // timing latched at start
		logic [7:0] gap_l;
		logic sck_r, ss_r, sl_act;
		logic [15:0] txsh, rxsh; // shifters, tx bit 0 on the pin
		logic sck_s1, sck_s2, sck_s3, ss_s1, ss_s2, ss_s3, sin_s1, sin_s2;
		logic ph_v, ph_w, rd_done; // ahb data phase
		logic [4:0] ph_addr;
		logic [31:0] rdata;
	} st_t;

	st_t s, n;
	logic tick, edge_ev, lead_e, is_samp, at_last, tx_push, tx_pop, rx_push, rx_pop, ovr;
	logic [15:0] pop_word, rx_word, rx_store;
	logic [4:0] last_edge, last_samp;
	logic [9:0] divm1;
	logic [31:0] rd_val;

	// bit reverse of an 8- or 16-bit unit into the low bits
	function automatic logic [15:0] rev_unit(input logic [15:0] w, input logic wide);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++) begin
			r[i] = w[15 - i];
		end
		return wide ? r : {8'h00, r[15:8]};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		n = s;
		// divisor zero behaves as one
		divm1 = (s.div == 10'h000) ? 10'h000 : s.div - 10'h001;
		tick = (s.state != spi_fifo_port_pkg::M_IDLE) && (s.hcnt == divm1);
		last_edge = s.size16 ? spi_fifo_port_pkg::LAST_EDGE_16 : spi_fifo_port_pkg::LAST_EDGE_8;
		last_samp = last_edge - {4'h0, ~s.cpha};
		pop_word = s.lsb ? s.txm[s.tx_rp] : rev_unit(s.txm[s.tx_rp], s.size16);
		tx_push = 1'b0;
		tx_pop = 1'b0;
		rx_pop = 1'b0;
		// pin synchronisers
		n.sck_s1 = shift_clock_pin_i;
		n.sck_s2 = s.sck_s1;
		n.sck_s3 = s.sck_s2;
		n.ss_s1 = select_line_i;
		n.ss_s2 = s.ss_s1;
		n.ss_s3 = s.ss_s2;
		n.sin_s1 = serial_in_pin_i;
		n.sin_s2 = s.sin_s1;
		// divider runs only while the master sequencer is busy
		n.hcnt = (s.state == spi_fifo_port_pkg::M_IDLE || tick) ? 10'h000 : s.hcnt + 10'h001;

		// edge source: own clock in master, synchronised pin in slave
		if (s.mst) begin
			edge_ev = (s.state == spi_fifo_port_pkg::M_SHIFT) && tick;
			lead_e = ~s.ecnt[0];
		end else begin
			edge_ev = s.en && s.sl_act && !s.ss_s2 && (s.sck_s3 != s.sck_s2);
			lead_e = (s.sck_s3 == s.cpol);
		end
		is_samp = lead_e ^ s.cpha;
		at_last = edge_ev && (s.ecnt == last_edge);
		rx_word = {s.rxsh[14:0], s.sin_s2};
		rx_push = edge_ev && is_samp && (s.ecnt == last_samp);
		rx_store = s.lsb ? rev_unit(rx_word, s.size16) : (s.size16 ? rx_word : {8'h00, rx_word[7:0]});

		// shift engine shared by both modes
		if (edge_ev) begin
			if (is_samp) begin
				n.rxsh = rx_word;
			end else if (s.ecnt != 5'h00 && !at_last) begin
				n.txsh = {1'b0, s.txsh[15:1]};
			end
			n.ecnt = at_last ? 5'h00 : s.ecnt + 5'h01;
			if (s.mst) begin
				n.sck_r = ~s.sck_r;
			end
		end

		// slave framing on the select input
		if (!s.mst && s.en) begin
			if (s.ss_s3 && !s.ss_s2) begin
				// select fell: new unit, first bit on the pin
				n.sl_act = 1'b1;
				n.ecnt = 5'h00;
				tx_pop = (s.tx_cnt != 3'h0);
				n.txsh = tx_pop ? pop_word : spi_fifo_port_pkg::EMPTY_FILL;
			end else if (s.ss_s2) begin
				n.sl_act = 1'b0;
			end else if (at_last) begin
				// next unit loaded after the last edge
				tx_pop = (s.tx_cnt != 3'h0);
				n.txsh = tx_pop ? pop_word : spi_fifo_port_pkg::EMPTY_FILL;
			end
		end

		// master sequencer
		unique case (s.state)
			spi_fifo_port_pkg::M_IDLE: begin
				n.sck_r = s.cpol;
				n.ss_r = 1'b1;
				n.tcnt = 9'h000;
				if (s.en && s.mst && s.tx_cnt != 3'h0) begin
					// lead, lag and gap frozen for the whole transfer
					n.lead_l = s.lead;
					n.lag_l = s.lag;
					n.gap_l = s.gap;
					if (s.moz || s.soz || s.ssz) begin
						n.state = spi_fifo_port_pkg::M_GUARD;
					end else begin
						n.state = spi_fifo_port_pkg::M_LEAD;
						n.ss_r = 1'b0;
						tx_pop = 1'b1;
						n.txsh = pop_word;
					end
				end
			end
			spi_fifo_port_pkg::M_GUARD: begin
				if (tick) begin
					n.tcnt = s.tcnt + 9'h001;
					if (s.tcnt == spi_fifo_port_pkg::GUARD_HALF) begin
						n.state = spi_fifo_port_pkg::M_LEAD;
						n.tcnt = 9'h000;
						n.ss_r = 1'b0;
						tx_pop = 1'b1;
						n.txsh = pop_word;
					end
				end
			end
			spi_fifo_port_pkg::M_LEAD: begin
				if (tick) begin
					n.tcnt = s.tcnt + 9'h001;
					if (s.tcnt == {7'h00, s.lead_l}) begin
						n.state = spi_fifo_port_pkg::M_SHIFT;
						n.tcnt = 9'h000;
						n.ecnt = 5'h00;
					end
				end
			end
			spi_fifo_port_pkg::M_SHIFT: begin
				if (at_last) begin
					if (s.gap_l == 8'h00 && s.tx_cnt != 3'h0) begin
						// no gap: next unit follows with select held low
						tx_pop = 1'b1;
						n.txsh = pop_word;
					end else begin
						n.state = spi_fifo_port_pkg::M_LAG;
					end
				end
			end
			spi_fifo_port_pkg::M_LAG: begin
				if (tick) begin
					n.tcnt = s.tcnt + 9'h001;
					if (s.tcnt == {7'h00, s.lag_l}) begin
						n.ss_r = 1'b1;
						n.tcnt = 9'h000;
						// empty fifo: select stays high until new data
						n.state = (s.gap_l != 8'h00 && s.tx_cnt != 3'h0) ?
							spi_fifo_port_pkg::M_GAP : spi_fifo_port_pkg::M_IDLE;
					end
				end
			end
			spi_fifo_port_pkg::M_GAP: begin
				if (tick) begin
					n.tcnt = s.tcnt + 9'h001;
					if (s.tcnt == {s.gap_l, 1'b0} - 9'h001) begin
						n.tcnt = 9'h000;
						if (s.tx_cnt != 3'h0) begin
							n.state = spi_fifo_port_pkg::M_LEAD;
							n.ss_r = 1'b0;
							tx_pop = 1'b1;
							n.txsh = pop_word;
						end else begin
							n.state = spi_fifo_port_pkg::M_IDLE;
						end
					end
				end
			end
		endcase

		////////////////////////////////////////////////////////////////////
		// register writes in the data phase
		if (s.ph_v && s.ph_w) begin
			unique case (s.ph_addr)
				spi_fifo_port_pkg::OFS_CTRL: begin
					{n.ssz, n.soz, n.moz, n.mdfe, n.flush, n.size16} = hwdata_i[10:5];
					{n.lsb, n.cpha, n.cpol, n.mst, n.en} = hwdata_i[4:0];
				end
				spi_fifo_port_pkg::OFS_DIV: begin
					n.div = hwdata_i[spi_fifo_port_pkg::D_DIV +: 10];
					n.lead = (hwdata_i[spi_fifo_port_pkg::D_LEAD +: 2] > spi_fifo_port_pkg::LEADLAG_MAX) ?
						spi_fifo_port_pkg::LEADLAG_MAX : hwdata_i[spi_fifo_port_pkg::D_LEAD +: 2];
					n.lag = (hwdata_i[spi_fifo_port_pkg::D_LAG +: 2] > spi_fifo_port_pkg::LEADLAG_MAX) ?
						spi_fifo_port_pkg::LEADLAG_MAX : hwdata_i[spi_fifo_port_pkg::D_LAG +: 2];
				end
				spi_fifo_port_pkg::OFS_GAP: n.gap = hwdata_i[7:0];
				spi_fifo_port_pkg::OFS_INTC: begin
					n.tth = hwdata_i[spi_fifo_port_pkg::I_TTH +: 3];
					n.rth = hwdata_i[spi_fifo_port_pkg::I_RTH +: 3];
					n.ien = hwdata_i[spi_fifo_port_pkg::I_IEN +: 4];
				end
				spi_fifo_port_pkg::OFS_TXD: tx_push = 1'b1;
				default: begin
				end
			endcase
		end
		// write-one clears, overridden below by a set in the same cycle
		if (s.ph_v && s.ph_w && s.ph_addr == spi_fifo_port_pkg::OFS_STAT) begin
			n.f_tth = s.f_tth & ~hwdata_i[spi_fifo_port_pkg::S_TTH];
			n.f_rth = s.f_rth & ~hwdata_i[spi_fifo_port_pkg::S_RTH];
			n.f_end = s.f_end & ~hwdata_i[spi_fifo_port_pkg::S_END];
			n.f_ovr = s.f_ovr & ~hwdata_i[spi_fifo_port_pkg::S_OVR];
			n.f_mdf = s.f_mdf & ~hwdata_i[spi_fifo_port_pkg::S_MDF];
			n.f_done = s.f_done & ~hwdata_i[spi_fifo_port_pkg::S_DONE];
			n.f_wof = s.f_wof & ~hwdata_i[spi_fifo_port_pkg::S_WOF];
		end

		////////////////////////////////////////////////////////////////////
		// register reads, one wait state, side effects here
		unique case (s.ph_addr)
			spi_fifo_port_pkg::OFS_CTRL: rd_val = {21'h000000, s.ssz, s.soz, s.moz, s.mdfe,
				s.flush, s.size16, s.lsb, s.cpha, s.cpol, s.mst, s.en};
			spi_fifo_port_pkg::OFS_DIV: rd_val = {10'h000, s.lag, 2'h0, s.lead, 6'h00, s.div};
			spi_fifo_port_pkg::OFS_GAP: rd_val = {24'h000000, s.gap};
			spi_fifo_port_pkg::OFS_INTC: rd_val = {20'h00000, s.ien, 1'b0, s.rth, 1'b0, s.tth};
			spi_fifo_port_pkg::OFS_STAT: rd_val = {12'h000,
				s.rx_cnt == spi_fifo_port_pkg::FIFO_FULL, s.rx_cnt == 3'h0,
				s.tx_cnt == spi_fifo_port_pkg::FIFO_FULL, s.tx_cnt == 3'h0,
				7'h00, s.f_wof, 2'h0, s.f_done, s.f_mdf, s.f_ovr, s.f_end, s.f_rth, s.f_tth};
			spi_fifo_port_pkg::OFS_DEPTH: rd_val = {21'h000000, s.rx_cnt, 5'h00, s.tx_cnt};
			spi_fifo_port_pkg::OFS_RXD: rd_val = {16'h0000, s.rxm[s.rx_rp]};
			default: rd_val = 32'h00000000;
		endcase
		if (s.ph_v && !s.ph_w && !s.rd_done) begin
			n.rdata = rd_val;
			n.rd_done = 1'b1;
			if (s.ph_addr == spi_fifo_port_pkg::OFS_STAT) begin
				n.f_wof = 1'b0;
			end
			rx_pop = (s.ph_addr == spi_fifo_port_pkg::OFS_RXD) && (s.rx_cnt != 3'h0);
		end

		////////////////////////////////////////////////////////////////////
		// fifos and event flags
		if (tx_push && s.tx_cnt == spi_fifo_port_pkg::FIFO_FULL) begin
			tx_push = 1'b0;
			n.f_wof = 1'b1;
		end
		if (tx_push) begin
			n.txm[s.tx_rp + s.tx_cnt[1:0]] = hwdata_i[15:0];
		end
		ovr = rx_push && (s.rx_cnt == spi_fifo_port_pkg::FIFO_FULL) && !rx_pop;
		if (rx_push && !ovr) begin
			n.rxm[s.rx_rp + s.rx_cnt[1:0]] = rx_store;
		end
		n.tx_rp = s.tx_rp + {1'b0, tx_pop};
		n.rx_rp = s.rx_rp + {1'b0, rx_pop};
		n.tx_cnt = s.tx_cnt + {2'h0, tx_push} - {2'h0, tx_pop};
		n.rx_cnt = s.rx_cnt + {2'h0, rx_push && !ovr} - {2'h0, rx_pop};
		if (s.flush) begin
			// counters only; flags and settings are kept
			n.tx_rp = 2'h0;
			n.rx_rp = 2'h0;
			n.tx_cnt = 3'h0;
			n.rx_cnt = 3'h0;
		end
		if (ovr) begin
			n.f_ovr = 1'b1;
		end
		// flags land one clock after the sampling edge of the last bit
		if (rx_push) begin
			n.f_done = 1'b1;
			if (s.tx_cnt == 3'h0) begin
				n.f_end = 1'b1;
			end
			if (!ovr && s.rx_cnt + 3'h1 >= s.rth) begin
				n.f_rth = 1'b1;
			end
		end
		if (edge_ev && s.ecnt == spi_fifo_port_pkg::TTH_EDGE && s.tx_cnt == s.tth) begin
			n.f_tth = 1'b1;
		end

		// mode fault: another master pulled select low
		if (s.en && s.mst && !s.ss_s2) begin
			n.mst = 1'b0;
			n.en = 1'b0;
			n.f_mdf = 1'b1;
			n.state = spi_fifo_port_pkg::M_IDLE;
			n.ss_r = 1'b1;
		end

		// ahb address phase
		if (hready_i) begin
			n.ph_v = hsel_i && htrans_i[1];
			n.ph_w = hwrite_i;
			n.ph_addr = {haddr_i[4:2], 2'b00};
			n.rd_done = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s <= '0;
			s.div <= spi_fifo_port_pkg::DIV_RST;
			s.lead <= spi_fifo_port_pkg::LEADLAG_RST;
			s.lag <= spi_fifo_port_pkg::LEADLAG_RST;
			s.rth <= spi_fifo_port_pkg::RTH_RST;
			s.state <= spi_fifo_port_pkg::M_IDLE;
			s.ss_r <= 1'b1;
			s.txsh <= spi_fifo_port_pkg::EMPTY_FILL;
			{s.ss_s1, s.ss_s2, s.ss_s3} <= 3'h7;
		end else begin
			s <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign hrdata_o = s.rdata;
	assign hreadyout_o = !(s.ph_v && !s.ph_w && !s.rd_done);
	assign hresp_o = 1'b0;
	assign shift_clock_pin_o = s.sck_r;
	assign select_line_o = s.ss_r;
	assign serial_out_pin_o = s.txsh[0];
	// clock and select released outside master mode; floats release master data and select while idle, slave data while unselected
	assign shift_clock_pin_oe_o = s.mst;
	assign select_line_oe_o = s.mst && !(s.ssz && s.state == spi_fifo_port_pkg::M_IDLE);
	assign serial_out_pin_oe_o = s.mst ? !(s.moz && s.state == spi_fifo_port_pkg::M_IDLE) :
		(s.en && (!s.soz || s.sl_act));
	assign irq_o = |({s.f_ovr, s.f_end, s.f_rth, s.f_tth} & s.ien) || (s.f_mdf && s.mdfe);

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// cycles since the shift clock last changed
	logic [10:0] tog_cnt;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			tog_cnt <= 11'h000;
		end else begin
			tog_cnt <= (n.sck_r != s.sck_r) ? 11'h000 : tog_cnt + 11'h001;
		end
	end

	sequence s_fault_seen;
		s.en && s.mst && !s.ss_s2;
	endsequence
	sequence s_fault_taken;
		!s.mst && !s.en && s.f_mdf && select_line_o;
	endsequence

	chk_sck_half_period: assert property (
		(s.state == spi_fifo_port_pkg::M_SHIFT && s.ecnt != 5'h00 && n.sck_r != s.sck_r && s.mst)
		|-> tog_cnt == ((s.div == 10'h000) ? 11'h000 : {1'b0, s.div} - 11'h001))
		else $error("shift clock half period differs from divisor");
	chk_idle_levels: assert property (
		(s.state == spi_fifo_port_pkg::M_IDLE && $past(s.state) == spi_fifo_port_pkg::M_IDLE)
		|-> select_line_o && shift_clock_pin_o == s.cpol)
		else $error("idle master not at idle levels");
	chk_wof_set: assert property (
		(s.ph_v && s.ph_w && s.ph_addr == spi_fifo_port_pkg::OFS_TXD
		&& s.tx_cnt == spi_fifo_port_pkg::FIFO_FULL && !s.flush) |=> s.f_wof && s.tx_cnt != 3'h0)
		else $error("write to full fifo left no overflow flag");
	chk_ovr_drop: assert property (
		(rx_push && s.rx_cnt == spi_fifo_port_pkg::FIFO_FULL && !rx_pop && !s.flush)
		|=> s.f_ovr && s.rx_cnt == spi_fifo_port_pkg::FIFO_FULL && $stable(s.rxm))
		else $error("overrun not flagged or unit stored");
	chk_mode_fault: assert property (s_fault_seen |=> s_fault_taken)
		else $error("mode fault not taken");
	chk_flush_empty: assert property (s.flush |=> s.tx_cnt == 3'h0 && s.rx_cnt == 3'h0)
		else $error("flush left data in a fifo");
	chk_slave_ones: assert property (
		(!s.mst && s.en && s.ss_s3 && !s.ss_s2 && s.tx_cnt == 3'h0)
		|=> s.txsh == spi_fifo_port_pkg::EMPTY_FILL && serial_out_pin_o)
		else $error("empty slave does not send ones");
	chk_end_flag: assert property ((rx_push && s.tx_cnt == 3'h0) |=> s.f_end && s.f_done)
		else $error("transfer end not flagged");
	chk_lead_hold: assert property (
		(s.state == spi_fifo_port_pkg::M_LEAD && s.mst) |-> !select_line_o && shift_clock_pin_o == s.cpol)
		else $error("clock moved during lead time");

endmodule

// ---- design/spi_fifo_port_pkg.sv ----
// constants, register map and types of the serial port with fifos
package spi_fifo_port_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes
	localparam int unsigned UNIT_W = 16; // widest unit
	localparam logic [2:0] FIFO_FULL = 3'h4; // entries per fifo

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00; // control_register
	localparam logic [4:0] OFS_DIV = 5'h04; // divider_register
	localparam logic [4:0] OFS_GAP = 5'h08; // gap_control_register
	localparam logic [4:0] OFS_INTC = 5'h0C; // interrupt_control_register
	localparam logic [4:0] OFS_STAT = 5'h10; // event_status_register
	localparam logic [4:0] OFS_DEPTH = 5'h14; // fifo_depth_register
	localparam logic [4:0] OFS_TXD = 5'h18; // tx_write_port
	localparam logic [4:0] OFS_RXD = 5'h1C; // receive data, read pops

	////////////////////////////////////////////////////////////////////////
	// control bits
	localparam int unsigned C_EN = 0; // port_enable_bit
	localparam int unsigned C_MST = 1; // master_sel
	localparam int unsigned C_CPOL = 2; // clock_polarity
	localparam int unsigned C_CPHA = 3; // clock_phase
	localparam int unsigned C_LSB = 4; // bit_order_sel, 1 = lsb first
	localparam int unsigned C_SIZE = 5; // unit_size_sel, 1 = 16 bits
	localparam int unsigned C_FLUSH = 6; // fifo_flush
	localparam int unsigned C_MDFE = 7; // mode_fault_irq_enable
	localparam int unsigned C_MOZ = 8; // master_out_float
	localparam int unsigned C_SOZ = 9; // slave_out_float
	localparam int unsigned C_SSZ = 10; // select_float

	// divider fields
	localparam int unsigned D_DIV = 0; // clock_divisor, 10 bits
	localparam int unsigned D_LEAD = 16; // lead, half clocks minus one
	localparam int unsigned D_LAG = 20; // lag, half clocks minus one
	localparam logic [9:0] DIV_RST = 10'h001;
	localparam logic [1:0] LEADLAG_RST = 2'h1;
	localparam logic [1:0] LEADLAG_MAX = 2'h2; // 1.5 shift clocks

	// interrupt control fields
	localparam int unsigned I_TTH = 0; // tx_threshold_sel
	localparam int unsigned I_RTH = 4; // rx_threshold_sel
	localparam int unsigned I_IEN = 8; // tx thr, rx thr, end, overrun
	localparam logic [2:0] RTH_RST = 3'h1;

	// status bits
	localparam int unsigned S_TTH = 0; // tx_threshold_flag
	localparam int unsigned S_RTH = 1; // rx_threshold_flag
	localparam int unsigned S_END = 2; // transfer_end_flag
	localparam int unsigned S_OVR = 3; // overrun_flag
	localparam int unsigned S_MDF = 4; // mode_fault_flag
	localparam int unsigned S_DONE = 5; // unit_done_flag
	localparam int unsigned S_WOF = 8; // write_overflow_flag
	localparam int unsigned S_TXE = 16; // tx_empty_flag
	localparam int unsigned S_TXF = 17; // tx_full_flag
	localparam int unsigned S_RXE = 18; // rx_empty_flag
	localparam int unsigned S_RXF = 19; // rx_full_flag
	localparam int unsigned F_RXD = 8; // rx_depth field of depth register

	////////////////////////////////////////////////////////////////////////
	// shift timing, in half shift clocks and edge counts
	localparam logic [8:0] GUARD_HALF = 9'h001; // one full shift clock
	localparam logic [4:0] LAST_EDGE_8 = 5'h0F;
	localparam logic [4:0] LAST_EDGE_16 = 5'h1F;
	localparam logic [4:0] TTH_EDGE = 5'h02; // edge of the second bit
	localparam logic [15:0] EMPTY_FILL = 16'hFFFF;

	// master sequencer
	typedef enum logic [2:0] {M_IDLE, M_GUARD, M_LEAD, M_SHIFT, M_LAG, M_GAP} mst_t;

endpackage

// ---- verification/spi_slave_model.sv ----
// behavioural serial slave standing at the far side of the master port
module spi_slave_model #(
	parameter logic [7:0] REPLY = 8'hA5 // answer byte, arbitrary
) (
	// serial pins seen from the far side
	input wire logic sck_i,
	input wire logic ss_n_i,
	input wire logic mosi_i,
	output logic miso_o,
	// last captured unit
	output logic [7:0] got_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] shreg = 8'h00; // outgoing bits
	logic [7:0] inreg = 8'h00; // incoming bits
	initial miso_o = 1'b0;
	initial got_o = 8'h00;
	////////////////////////////////////////////////////////////////////////
	// select fall loads the answer, first bit out at once
	always @(negedge ss_n_i) begin
		shreg = REPLY;
		miso_o = REPLY[7];
	end
	// sample on rising clock, msb first
	always @(posedge sck_i) begin
		if (!ss_n_i) inreg = {inreg[6:0], mosi_i};
	end
	// shift on falling clock
	always @(negedge sck_i) begin
		if (!ss_n_i) begin
			shreg = shreg << 1;
			miso_o = shreg[7];
		end
	end
	// released line shows no stale level
	always @(posedge ss_n_i) begin
		got_o = inreg;
		miso_o = ~miso_o;
	end
endmodule

// ---- verification/tb.sv ----
// self-checking bench: registers, master transfer, overflow, flush, mode fault
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	// bench drive
	logic clk_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, ss_drv = 1'b1, rd_dp = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'h13F20E77, r;
	logic [1:0] htrans = 2'h0;
	logic sck_drv = 1'b0; // external master clock for slave frames
	// design outputs
	logic [31:0] hrdata;
	logic hready, hresp, sck_o, sck_oe, ss_o, ss_oe, so, so_oe, irq, miso;
	logic [7:0] got, tx;
	logic [63:0] expq[$], e;
	int error_cnt = 0, num_checks = 0, hi;
	always #50 clk_i = ~clk_i;
	spi_fifo_port dut (.clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
		.shift_clock_pin_i(sck_oe ? sck_o : sck_drv), .shift_clock_pin_o(sck_o),
		.shift_clock_pin_oe_o(sck_oe), .select_line_i(ss_drv), .select_line_o(ss_o),
		.select_line_oe_o(ss_oe), .serial_out_pin_o(so), .serial_out_pin_oe_o(so_oe),
		.serial_in_pin_i(miso), .irq_o(irq));
	spi_slave_model peer (.sck_i(sck_o), .ss_n_i(ss_o), .mosi_i(so), .miso_o(miso),
		.got_o(got));
	////////////////////////////////////////////////////////////////////////
	// verdict and run end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] act, input logic [31:0] exp);
		num_checks++;
		if (act !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got %h exp %h", $time, act, exp);
		end
	endtask
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// one ahb single transfer, address then data phase
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		haddr <= {27'h0, a};
		hwrite <= wr;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 50);
		// address phase never taken
		if (n >= 50) begin error_cnt++; end_sim(); end
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wr ? d : 32'h0;
		rd_dp <= !wr;
		do begin @(posedge clk_i); n++; end while (hready !== 1'b1 && n < 100);
		rd_dp <= 1'b0;
		if (n >= 100) begin error_cnt++; end_sim(); end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// read, expected value noted for the watcher
	task automatic rd(input logic [4:0] a, input logic [31:0] exp, input logic [31:0] m);
		expq.push_back({exp, m});
		bus(1'b0, a, 32'h0);
	endtask
	// watcher: read data against the oldest note
	always @(posedge clk_i) begin
		if (rd_dp && hready === 1'b1 && expq.size() > 0) begin
			e = expq.pop_front();
			chk(hrdata & e[31:0], e[63:32]);
		end
	end
	// one select frame, counting clock-high cycles
	task automatic wait_frame();
		int n;
		hi = 0;
		n = 0;
		while (ss_o !== 1'b0 && n < 200) begin @(posedge clk_i); n++; end
		// select never fell
		if (n >= 200) begin error_cnt++; end_sim(); end
		while (ss_o !== 1'b1 && n < 2000) begin @(posedge clk_i); n++; hi += (sck_o === 1'b1); end
		repeat (4) @(posedge clk_i);
		if (n >= 2000) begin error_cnt++; end_sim(); end
	endtask
	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(spi_fifo_port_pkg::OFS_DIV, 32'h00110001, 32'h003303FF);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h00050000, 32'h000F013F);
		chk({ss_o, sck_o}, 32'h2);
		chk({28'h0, sck_oe, ss_oe, so_oe, hresp}, 32'h0);
		$display("test reset values done");
		wr(spi_fifo_port_pkg::OFS_DIV, 32'h00000004);
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h00000003);
		r = xs();
		tx = r[7:0];
		wr(spi_fifo_port_pkg::OFS_TXD, {24'h0, tx});
		wait_frame();
		chk(32'(hi), 32'h20);
		chk({24'h0, got}, {24'h0, tx});
		chk({28'h0, sck_oe, ss_oe, so_oe, hresp}, 32'hE);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h00010027, 32'h000F003F);
		rd(spi_fifo_port_pkg::OFS_RXD, 32'h000000A5, 32'h0000FFFF);
		$display("test master transfer done");
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h0);
		repeat (5) begin r = xs(); wr(spi_fifo_port_pkg::OFS_TXD, r & 32'hFF); end
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h00020100, 32'h00030100);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h0, 32'h00000100);
		rd(spi_fifo_port_pkg::OFS_DEPTH, 32'h4, 32'h00000707);
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h00000040);
		rd(spi_fifo_port_pkg::OFS_DEPTH, 32'h0, 32'h00000707);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h00050004, 32'h000F0004);
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h0);
		wr(spi_fifo_port_pkg::OFS_STAT, 32'h0000003F);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h0, 32'h0000003F);
		$display("test overflow and flush done");
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h00000083);
		ss_drv <= 1'b0;
		repeat (6) @(posedge clk_i);
		ss_drv <= 1'b1;
		chk({31'h0, irq}, 32'h1);
		rd(spi_fifo_port_pkg::OFS_STAT, 32'h10, 32'h00000010);
		rd(spi_fifo_port_pkg::OFS_CTRL, 32'h80, 32'h00000083);
		wr(spi_fifo_port_pkg::OFS_STAT, 32'h00000010);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		$display("test mode fault done");
		// slave frames: queued byte msb first, then all ones from an empty fifo
		wr(spi_fifo_port_pkg::OFS_CTRL, 32'h00000001);
		r = xs();
		tx = r[7:0];
		wr(spi_fifo_port_pkg::OFS_TXD, {24'h0, tx});
		repeat (2) begin
			ss_drv <= 1'b0;
			repeat (4) @(posedge clk_i);
			for (int b = 7; b >= 0; b--) begin
				repeat (4) @(posedge clk_i);
				chk({31'h0, so}, {31'h0, tx[b]});
				sck_drv <= 1'b1;
				repeat (4) @(posedge clk_i);
				sck_drv <= 1'b0;
			end
			repeat (4) @(posedge clk_i);
			ss_drv <= 1'b1;
			repeat (4) @(posedge clk_i);
			tx = 8'hFF;
		end
		$display("test slave frames done");
		end_sim();
	end
endmodule
